// *** verilog/usd_pkg.sv ***
// Contract
// - Select regulator feed: cable or boost switcher
// - Bus switch closes only with pin and select
// - Boost runs only from its own enable
// - Strap loads supply select at cold start
// - Grounded strap enables boost and regulator
// - Selecting OTG enables both USB regulators; cold-start strap select leaves aux off
// - OTG drive keeps bus interrupts and boost feed
// - Strap open: regulator follows bus voltage
// - Strap open: regulator enable forced back on
// - Over-voltage disables regulator and flags interrupt
// - Bus-valid debounce: rise 20 ms, fall 8 ms
// - Session-valid debounce: rise 20 ms, fall 8 ms
// - Each comparator has interrupt, sense, mask
// - Pull-up type: current source or resistor
// - Parallel pull-up independent of pull-up type
// - ID sense bits decoded from pin level
// - Separate maskable interrupt per ID condition
package usd_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_KHZ        = 125000;
  localparam int unsigned VBUS_RISE_MS   = 20;
  localparam int unsigned VBUS_FALL_MS   = 8;
  localparam int unsigned SESS_RISE_MS   = 20;
  localparam int unsigned SESS_FALL_MS   = 8;
  localparam int unsigned VBUS_RISE_CYC  = VBUS_RISE_MS * CLK_KHZ;
  localparam int unsigned VBUS_FALL_CYC  = VBUS_FALL_MS * CLK_KHZ;
  localparam int unsigned SESS_RISE_CYC  = SESS_RISE_MS * CLK_KHZ;
  localparam int unsigned SESS_FALL_CYC  = SESS_FALL_MS * CLK_KHZ;
  localparam int unsigned DB_CNT_W       = 23;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL_OFS    = 8'h00;
  localparam logic [7:0] REG_SENSE_OFS   = 8'h04;
  localparam logic [7:0] REG_FLAG_OFS    = 8'h08;
  localparam logic [7:0] REG_MASK_OFS    = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_OTG_SEL_BIT   = 0;
  localparam int unsigned CTRL_BOOST_EN_BIT  = 1;
  localparam int unsigned CTRL_REG_EN_BIT    = 2;
  localparam int unsigned CTRL_AUX_EN_BIT    = 3;
  localparam int unsigned CTRL_AUX_VSEL_LSB  = 4;
  localparam int unsigned CTRL_PU_TYPE_BIT   = 6;
  localparam int unsigned CTRL_PU_PAR_BIT    = 7;
  localparam int unsigned CTRL_W             = 8;

  // Event and sense bit positions (shared by sense, flag and mask)
  localparam int unsigned EV_VBUS_BIT    = 0;
  localparam int unsigned EV_SESS_BIT    = 1;
  localparam int unsigned EV_OVP_BIT     = 2;
  localparam int unsigned EV_IDFLT_BIT   = 3;
  localparam int unsigned EV_IDGND_BIT   = 4;
  localparam int unsigned EV_IDFAC_BIT   = 5;
  localparam int unsigned EV_W           = 6;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [EV_W-1:0]   MASK_RST = 6'h3F;
  localparam logic [EV_W-1:0]   FLAG_RST = 6'h00;

  // Aux regulator output levels in millivolts
  localparam logic [11:0] AUX_MV_0 = 12'h960;
  localparam logic [11:0] AUX_MV_1 = 12'hA28;
  localparam logic [11:0] AUX_MV_2 = 12'hA8C;
  localparam logic [11:0] AUX_MV_3 = 12'hAD7;

  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic id_factory;
    logic id_ground;
    logic id_float;
    logic ovp;
    logic sess_valid;
    logic vbus_valid;
  } usd_sense_s;

  typedef enum logic [1:0] {
    USD_ST_COLD = 2'b01,
    USD_ST_RUN  = 2'b10
  } usd_state_e;

  // Aux voltage code to millivolts
  function automatic logic [11:0] usd_aux_mv(input logic [1:0] code);
    logic [11:0] mv;
    mv = AUX_MV_0;
    unique case (code)
      2'b00: mv = AUX_MV_0;
      2'b01: mv = AUX_MV_1;
      2'b10: mv = AUX_MV_2;
      2'b11: mv = AUX_MV_3;
    endcase
    return mv;
  endfunction

endpackage

// *** verilog/usd_debounce.sv ***
`timescale 1ns/10ps
// Asymmetric debouncer: output follows input once it has held steady
module usd_debounce
  import usd_pkg::*;
#(
  parameter int unsigned RISE_CYC = 20,
  parameter int unsigned FALL_CYC = 8
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic raw_i,
  output logic      level_o
);

  logic [DB_CNT_W-1:0] cnt_q;
  logic                level_q;
  logic [DB_CNT_W-1:0] limit;

  // Limit depends on direction of the pending change
  assign limit = level_q ? DB_CNT_W'(FALL_CYC - 1) : DB_CNT_W'(RISE_CYC - 1);

  // Any bounce back restarts the count, so glitches never reach software
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else if (raw_i == level_q) begin
      cnt_q   <= '0;
    end else if (cnt_q >= limit) begin
      cnt_q   <= '0;
      level_q <= raw_i;
    end else begin
      cnt_q   <= cnt_q + DB_CNT_W'(1);
    end
  end

  assign level_o = level_q;

endmodule

// *** verilog/usd_top.sv ***
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
// USB supply selection and cable detection control
module usd_top
  import usd_pkg::*;
#(
  parameter int unsigned VBUS_RISE_CYC_P = VBUS_RISE_CYC,
  parameter int unsigned VBUS_FALL_CYC_P = VBUS_FALL_CYC,
  parameter int unsigned SESS_RISE_CYC_P = SESS_RISE_CYC,
  parameter int unsigned SESS_FALL_CYC_P = SESS_FALL_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Straps and system pins
  input  wire logic        power_up_strap_gnd_i,
  input  wire logic        system_reset_n_i,
  input  wire logic        vbus_drive_enable_pin_i,
  // Analog comparator results
  input  wire logic        vbus_cmp_i,
  input  wire logic        sess_cmp_i,
  input  wire logic        ovp_cmp_i,
  input  wire logic        id_above_gnd_i,
  input  wire logic        id_above_float_i,
  input  wire logic        id_above_factory_i,
  // Supply controls
  output logic             phy_reg_on_o,
  output logic             phy_reg_from_boost_o,
  output logic             bus_switch_close_o,
  output logic             boost_run_o,
  output logic             aux_reg_on_o,
  output logic [1:0]       aux_vsel_o,
  output logic [11:0]      aux_mv_o,
  // ID pin pull-up controls
  output logic             id_pullup_current_o,
  output logic             id_pullup_resistor_o,
  output logic             id_parallel_pullup_o,
  // Interrupt pin, active high
  output logic             interrupt_pin_o,
  output logic             vbus_overvoltage_irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  usd_state_e        state_q;
  logic              strap_gnd_q;
  logic              otg_sel_q;
  logic              boost_en_q;
  logic              reg_en_q;
  logic              aux_en_q;
  logic [1:0]        aux_vsel_q;
  logic              pu_type_q;
  logic              pu_par_q;
  logic [EV_W-1:0]   flag_q;
  logic [EV_W-1:0]   mask_q;
  usd_sense_s        sense_d;
  usd_sense_s        sense_q;
  logic              ovp_q;
  logic              vbus_db;
  logic              sess_db;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic              bus_req;
  logic              wr_ctrl;
  logic              wr_flag;
  logic              wr_mask;
  logic              otg_sel_rise;
  logic              vbus_lost;
  logic              force_reg_en;
  logic [EV_W-1:0]   ev_change;
  logic [CTRL_W-1:0] ctrl_rd;
  logic              phy_on_q;
  logic              irq_q;
  logic              ovp_irq_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Comparator debouncing
  usd_debounce #(
    .RISE_CYC (VBUS_RISE_CYC_P),
    .FALL_CYC (VBUS_FALL_CYC_P)
  ) u_vbus_db (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .raw_i     (vbus_cmp_i),
    .level_o   (vbus_db)
  );

  usd_debounce #(
    .RISE_CYC (SESS_RISE_CYC_P),
    .FALL_CYC (SESS_FALL_CYC_P)
  ) u_sess_db (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .raw_i     (sess_cmp_i),
    .level_o   (sess_db)
  );

  // Over-voltage is not debounced: the regulator must drop at once
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ovp_q <= 1'b0;
    end else begin
      ovp_q <= ovp_cmp_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sense bits
  always_comb begin
    sense_d            = '0;
    sense_d.vbus_valid = vbus_db;
    sense_d.sess_valid = sess_db;
    sense_d.ovp        = ovp_q;
    sense_d.id_float   = id_above_float_i;
    sense_d.id_ground  = id_above_gnd_i;
    sense_d.id_factory = id_above_factory_i;
  end

  // Sense register tracks current state
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sense_q <= sense_d;  // Pin levels at release are no event
    end else begin
      sense_q <= sense_d;
    end
  end

  // Any toggle of a sense bit is an event
  assign ev_change = sense_d ^ sense_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave decode
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_ctrl = bus_req & ack_q & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_CTRL_OFS);
  assign wr_flag = bus_req & ack_q & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_FLAG_OFS);
  assign wr_mask = bus_req & ack_q & wb_we_i & wb_sel_i[0] & (wb_adr_i == REG_MASK_OFS);

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  // Control readback packed into register layout
  always_comb begin
    ctrl_rd                                            = '0;
    ctrl_rd[CTRL_OTG_SEL_BIT]                          = otg_sel_q;
    ctrl_rd[CTRL_BOOST_EN_BIT]                         = boost_en_q;
    ctrl_rd[CTRL_REG_EN_BIT]                           = reg_en_q;
    ctrl_rd[CTRL_AUX_EN_BIT]                           = aux_en_q;
    ctrl_rd[CTRL_AUX_VSEL_LSB +: 2]                    = aux_vsel_q;
    ctrl_rd[CTRL_PU_TYPE_BIT]                          = pu_type_q;
    ctrl_rd[CTRL_PU_PAR_BIT]                           = pu_par_q;
  end

  // Read data captured at request; unmapped addresses read zero
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      dat_q <= 32'h0000_0000;
    end else if (bus_req & ~ack_q) begin
      unique case (wb_adr_i)
        REG_CTRL_OFS:  dat_q <= {24'h000000, ctrl_rd};
        REG_SENSE_OFS: dat_q <= {26'h0000000, sense_q};
        REG_FLAG_OFS:  dat_q <= {26'h0000000, flag_q};
        REG_MASK_OFS:  dat_q <= {26'h0000000, mask_q};
        default:       dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Cold start sequencing
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_q     <= USD_ST_COLD;
      strap_gnd_q <= 1'b0;
    end else begin
      unique case (state_q)
        USD_ST_COLD: begin
          strap_gnd_q <= power_up_strap_gnd_i;
          state_q     <= USD_ST_RUN;
        end
        USD_ST_RUN: begin
          state_q     <= USD_ST_RUN;
        end
        default: begin
          state_q     <= USD_ST_COLD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Supply select and boost enable
  assign otg_sel_rise = wr_ctrl & wb_dat_i[CTRL_OTG_SEL_BIT] & ~otg_sel_q;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      otg_sel_q  <= CTRL_RST[CTRL_OTG_SEL_BIT];
      boost_en_q <= CTRL_RST[CTRL_BOOST_EN_BIT];
    end else if (state_q == USD_ST_COLD) begin
      otg_sel_q  <= power_up_strap_gnd_i;
      boost_en_q <= power_up_strap_gnd_i;
    end else if (wr_ctrl) begin
      otg_sel_q  <= wb_dat_i[CTRL_OTG_SEL_BIT];
      boost_en_q <= wb_dat_i[CTRL_BOOST_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator enable with hardware re-arm
  // With strap open, falling bus valid or system reset re-enables, and beats a software clear
  assign vbus_lost    = sense_q.vbus_valid & ~vbus_db;
  assign force_reg_en = ~strap_gnd_q & (~system_reset_n_i | vbus_lost);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      reg_en_q <= CTRL_RST[CTRL_REG_EN_BIT];
    end else if (state_q == USD_ST_COLD) begin
      reg_en_q <= 1'b1;
    end else if (force_reg_en | otg_sel_rise) begin
      reg_en_q <= 1'b1;
    end else if (wr_ctrl) begin
      reg_en_q <= wb_dat_i[CTRL_REG_EN_BIT];
    end
  end

  // Aux regulator enable and voltage code
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      aux_en_q   <= CTRL_RST[CTRL_AUX_EN_BIT];
      aux_vsel_q <= CTRL_RST[CTRL_AUX_VSEL_LSB +: 2];
    end else if (otg_sel_rise) begin
      aux_en_q   <= 1'b1;
      aux_vsel_q <= wb_dat_i[CTRL_AUX_VSEL_LSB +: 2];
    end else if (wr_ctrl) begin
      aux_en_q   <= wb_dat_i[CTRL_AUX_EN_BIT];
      aux_vsel_q <= wb_dat_i[CTRL_AUX_VSEL_LSB +: 2];
    end
  end

  // ID pull-up configuration
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pu_type_q <= CTRL_RST[CTRL_PU_TYPE_BIT];
      pu_par_q  <= CTRL_RST[CTRL_PU_PAR_BIT];
    end else if (wr_ctrl) begin
      pu_type_q <= wb_dat_i[CTRL_PU_TYPE_BIT];
      pu_par_q  <= wb_dat_i[CTRL_PU_PAR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator on and feed; with cable feed selected it stays off with no bus voltage
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      phy_on_q <= 1'b0;
    end else if (ovp_cmp_i) begin
      phy_on_q <= 1'b0;
    end else begin
      phy_on_q <= reg_en_q & (otg_sel_q | vbus_cmp_i);
    end
  end

  assign phy_reg_on_o         = phy_on_q;
  assign phy_reg_from_boost_o = otg_sel_q;
  assign bus_switch_close_o   = otg_sel_q & vbus_drive_enable_pin_i;
  assign boost_run_o          = boost_en_q;
  assign aux_reg_on_o         = aux_en_q;
  assign aux_vsel_o           = aux_vsel_q;
  assign aux_mv_o             = usd_aux_mv(aux_vsel_q);
  assign id_pullup_current_o  = pu_type_q;
  assign id_pullup_resistor_o = ~pu_type_q;
  assign id_parallel_pullup_o = pu_par_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt flags: write one to clear, new event wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      flag_q <= FLAG_RST;
    end else begin
      flag_q <= (flag_q & ~(wr_flag ? wb_dat_i[EV_W-1:0] : '0)) | ev_change;
    end
  end

  // Mask set means that event is kept off the pin
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mask_q <= MASK_RST;
    end else if (wr_mask) begin
      mask_q <= wb_dat_i[EV_W-1:0];
    end
  end

  // Registered outputs so the pin never glitches on decode
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      irq_q     <= 1'b0;
      ovp_irq_q <= 1'b0;
    end else begin
      irq_q     <= |(flag_q & ~mask_q);
      ovp_irq_q <= flag_q[EV_OVP_BIT] & ~mask_q[EV_OVP_BIT];
    end
  end

  assign interrupt_pin_o        = irq_q;
  assign vbus_overvoltage_irq_o = ovp_irq_q;

endmodule

// *** tb/usd_checker.sv ***
`timescale 1ns/10ps
// Port-level timing and decode checks
module usd_checker
  import usd_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic        power_up_strap_gnd_i,
  input wire logic        system_reset_n_i,
  input wire logic        vbus_drive_enable_pin_i,
  input wire logic        vbus_cmp_i,
  input wire logic        ovp_cmp_i,
  input wire logic        phy_reg_on_o,
  input wire logic        phy_reg_from_boost_o,
  input wire logic        bus_switch_close_o,
  input wire logic        boost_run_o,
  input wire logic        aux_reg_on_o,
  input wire logic [1:0]  aux_vsel_o,
  input wire logic [11:0] aux_mv_o,
  input wire logic        id_pullup_current_o,
  input wire logic        id_pullup_resistor_o,
  input wire logic        interrupt_pin_o,
  input wire logic        vbus_overvoltage_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////
  // Supply path
  bus_switch_a: assert property (
    bus_switch_close_o == (phy_reg_from_boost_o && vbus_drive_enable_pin_i))
    else $error("bus switch state wrong");
  // Boost moves only by a register write or the cold-start load
  boost_hold_a: assert property (
    $changed(boost_run_o) |-> $past(wb_ack_o && wb_we_i) || !$past(resetn_i, 2)
      || !$past(resetn_i, 3))
    else $error("boost changed without a write");
  otg_auto_a: assert property (
    wb_ack_o && wb_we_i && wb_adr_i == REG_CTRL_OFS && wb_sel_i[0] && wb_dat_i[0]
      && !phy_reg_from_boost_o |=> phy_reg_from_boost_o && aux_reg_on_o)
    else $error("otg select did not enable regulators");
  ovp_off_a: assert property (ovp_cmp_i |=> !phy_reg_on_o)
    else $error("regulator on during over-voltage");
  ovp_irq_a: assert property (vbus_overvoltage_irq_o |-> interrupt_pin_o)
    else $error("over-voltage irq without interrupt pin");
  // Held two cycles so the enable register has settled first
  reg_force_a: assert property (
    (!system_reset_n_i && !power_up_strap_gnd_i && vbus_cmp_i && !ovp_cmp_i)[*2]
      |=> phy_reg_on_o)
    else $error("regulator enable not forced on");
  ////////////////////////////////////////////////////////////
  // Decodes and bus handshake
  pullup_type_a: assert property (id_pullup_current_o != id_pullup_resistor_o)
    else $error("pull-up type outputs not exclusive");
  aux_level_a: assert property (
    aux_mv_o == (aux_vsel_o == 2'h0 ? AUX_MV_0 : aux_vsel_o == 2'h1 ? AUX_MV_1 :
                 aux_vsel_o == 2'h2 ? AUX_MV_2 : AUX_MV_3))
    else $error("aux level decode wrong");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  cover property (ovp_cmp_i ##1 !phy_reg_on_o);
  cover property ($rose(bus_switch_close_o));
  cover property ($rose(interrupt_pin_o));
endmodule

bind usd_top usd_checker usd_checker_i (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .power_up_strap_gnd_i,
  .system_reset_n_i, .vbus_drive_enable_pin_i, .vbus_cmp_i, .ovp_cmp_i, .phy_reg_on_o,
  .phy_reg_from_boost_o, .bus_switch_close_o, .boost_run_o, .aux_reg_on_o, .aux_vsel_o,
  .aux_mv_o, .id_pullup_current_o, .id_pullup_resistor_o, .interrupt_pin_o,
  .vbus_overvoltage_irq_o);

// *** tb/usd_cable_model.sv ***
`timescale 1ns/10ps
// Cable side: host, charger or accessory seen through the comparators
module usd_cable_model (
  input  wire logic       clk_sys_i,
  input  wire logic       attach_i,
  input  wire logic       ovp_i,
  input  wire logic [1:0] id_mode_i,
  output logic            vbus_cmp_o,
  output logic            sess_cmp_o,
  output logic            ovp_cmp_o,
  output logic            id_gnd_o,
  output logic            id_flt_o,
  output logic            id_fac_o
);
  logic [1:0] bounce_q = 2'h0;
  logic       att_q    = 1'b0;
  // Contact bounce after plug or unplug, so a missing debounce shows
  always_ff @(posedge clk_sys_i) begin
    att_q <= attach_i;
    if (att_q != attach_i) begin
      bounce_q <= 2'h3;
    end else if (bounce_q != 2'h0) begin
      bounce_q <= bounce_q - 2'h1;
    end
  end
  assign vbus_cmp_o = (bounce_q != 2'h0) ? (bounce_q[0] ^ attach_i) : attach_i;
  assign sess_cmp_o = vbus_cmp_o;
  assign ovp_cmp_o  = ovp_i;
  // Plug kinds: 0 resistor, 1 grounded, 2 floating, 3 applied voltage
  assign id_gnd_o = (id_mode_i != 2'h1);
  assign id_flt_o = id_mode_i[1];
  assign id_fac_o = (id_mode_i == 2'h3);
endmodule

// *** tb/usd_supply_and_detect_control_tb_top.sv ***
`timescale 1ns/10ps
module usd_supply_and_detect_control_tb_top import usd_pkg::*;;
  logic        clk_sys_i = 1'b0, resetn_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, lfsr_q = 32'hFCDE0987;
  logic        power_up_strap_gnd_i = 1'b0, system_reset_n_i = 1'b1;
  logic        vbus_drive_enable_pin_i = 1'b0, attach = 1'b0, ovp = 1'b0;
  logic [1:0]  id_mode = 2'h2, aux_vsel_o;
  logic        vbus_cmp_i, sess_cmp_i, ovp_cmp_i, id_above_gnd_i, id_above_float_i;
  logic        id_above_factory_i, phy_reg_on_o, phy_reg_from_boost_o, bus_switch_close_o;
  logic        boost_run_o, aux_reg_on_o, id_pullup_current_o, id_pullup_resistor_o;
  logic        id_parallel_pullup_o, interrupt_pin_o, vbus_overvoltage_irq_o;
  logic [11:0] aux_mv_o;
  int          err_total = 0, checks_done = 0;

  // Short debounce counts keep the run brief: 20/8 bus, 30/10 session
  usd_top #(.VBUS_RISE_CYC_P(20), .VBUS_FALL_CYC_P(8), .SESS_RISE_CYC_P(30),
    .SESS_FALL_CYC_P(10)) usd_top_i (.clk_sys_i, .resetn_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .power_up_strap_gnd_i, .system_reset_n_i, .vbus_drive_enable_pin_i, .vbus_cmp_i,
    .sess_cmp_i, .ovp_cmp_i, .id_above_gnd_i, .id_above_float_i, .id_above_factory_i,
    .phy_reg_on_o, .phy_reg_from_boost_o, .bus_switch_close_o, .boost_run_o,
    .aux_reg_on_o, .aux_vsel_o, .aux_mv_o, .id_pullup_current_o, .id_pullup_resistor_o,
    .id_parallel_pullup_o, .interrupt_pin_o, .vbus_overvoltage_irq_o);
  usd_cable_model usd_cable_model_i (.clk_sys_i, .attach_i(attach), .ovp_i(ovp),
    .id_mode_i(id_mode), .vbus_cmp_o(vbus_cmp_i), .sess_cmp_o(sess_cmp_i),
    .ovp_cmp_o(ovp_cmp_i), .id_gnd_o(id_above_gnd_i), .id_flt_o(id_above_float_i),
    .id_fac_o(id_above_factory_i));

  // Clock and hang guard; the run needs well under 2000 cycles
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    chk(32'h1, 32'h0);
    complete_run();
  end

  ////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] want_id(input logic [1:0] m);
    return (m == 2'h0) ? 3'b010 : (m == 2'h1) ? 3'b000 : (m == 2'h2) ? 3'b011 : 3'b111;
  endfunction
  function automatic logic [11:0] want_mv(input logic [1:0] c);
    return (c == 2'h0) ? 12'h960 : (c == 2'h1) ? 12'hA28 : (c == 2'h2) ? 12'hA8C : 12'hAD7;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Classic cycle: hold until ack is seen, take data, release on that edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(32'(n >= 40), 32'h0);
  endtask
  task automatic do_reset(input logic gnd);
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    power_up_strap_gnd_i <= gnd;
    repeat (10) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    tick(3);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  initial begin
    int prev;
    logic [7:0] d;
    do_reset(1'b0);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rd, 32'h04);
    wb_sel_i <= 4'h0;
    wb(1'b1, REG_MASK_OFS, 32'h0);
    wb_sel_i <= 4'hF;
    wb(1'b0, REG_MASK_OFS, 32'h0);
    chk(rd, 32'h3F);
    wb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk({phy_reg_on_o, aux_mv_o}, {1'b0, 12'h960});
    wb(1'b0, REG_FLAG_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("test cold start done");
    // Plug in a host: bus valid settles before session valid
    @(posedge clk_sys_i);
    attach <= 1'b1;
    tick(14);
    wb(1'b0, REG_SENSE_OFS, 32'h0);
    chk(rd[1:0], 2'h0);
    tick(11);
    wb(1'b0, REG_SENSE_OFS, 32'h0);
    chk(rd[1:0], 2'h1);
    tick(20);
    wb(1'b0, REG_SENSE_OFS, 32'h0);
    chk({phy_reg_on_o, rd[1:0]}, 3'h7);
    wb(1'b1, REG_MASK_OFS, 32'h3E);
    tick(2);
    chk(interrupt_pin_o, 1'b1);
    wb(1'b1, REG_FLAG_OFS, 32'h01);
    tick(2);
    chk(interrupt_pin_o, 1'b0);
    wb(1'b1, REG_MASK_OFS, 32'h3F);
    // Software disable undone by the system reset pin, then by unplug
    wb(1'b1, REG_CTRL_OFS, 32'h0);
    tick(2);
    chk(phy_reg_on_o, 1'b0);
    @(posedge clk_sys_i);
    system_reset_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    system_reset_n_i <= 1'b1;
    tick(1);
    chk(phy_reg_on_o, 1'b1);
    wb(1'b1, REG_CTRL_OFS, 32'h0);
    @(posedge clk_sys_i);
    attach <= 1'b0;
    tick(3);
    wb(1'b0, REG_SENSE_OFS, 32'h0);
    chk(rd[1:0], 2'h3);
    tick(25);
    wb(1'b0, REG_SENSE_OFS, 32'h0);
    chk(rd[1:0], 2'h0);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk(rd[2], 1'b1);
    $display("test detect done");
    // Random pull-up and aux settings, every aux code twice
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      d = {lfsr_q[1:0], i[1:0], 4'h4};
      wb(1'b1, REG_CTRL_OFS, {24'h0, d});
      wb(1'b0, REG_CTRL_OFS, 32'h0);
      chk(rd, {24'h0, d});
      chk(aux_mv_o, want_mv(d[5:4]));
      chk({id_pullup_current_o, id_pullup_resistor_o, id_parallel_pullup_o},
          {d[6], !d[6], d[7]});
    end
    prev = 2;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys_i);
      id_mode <= m[1:0];
      tick(4);
      wb(1'b0, REG_SENSE_OFS, 32'h0);
      chk(rd[5:3], want_id(m[1:0]));
      wb(1'b0, REG_FLAG_OFS, 32'h0);
      chk(rd[5:3], want_id(m[1:0]) ^ want_id(prev[1:0]));
      wb(1'b1, REG_FLAG_OFS, 32'h38);
      prev = m;
    end
    $display("test id and settings done");
    // OTG: select boost feed, then drive the bus; boost held off by software
    wb(1'b1, REG_CTRL_OFS, 32'h01);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk({phy_reg_from_boost_o, rd}, {1'b1, 32'h0D});
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_sys_i);
      vbus_drive_enable_pin_i <= e[0];
      tick(1);
      chk({bus_switch_close_o, boost_run_o}, {e[0], 1'b0});
    end
    wb(1'b1, REG_CTRL_OFS, 32'h0F);
    tick(1);
    chk(boost_run_o, 1'b1);
    wb(1'b1, REG_FLAG_OFS, 32'h03);
    @(posedge clk_sys_i);
    attach <= 1'b1;
    tick(50);
    wb(1'b0, REG_FLAG_OFS, 32'h0);
    chk({phy_reg_from_boost_o, rd[1:0]}, 3'h7);
    @(posedge clk_sys_i);
    ovp <= 1'b1;
    tick(2);
    chk(phy_reg_on_o, 1'b0);
    wb(1'b1, REG_MASK_OFS, 32'h3B);
    tick(2);
    chk(vbus_overvoltage_irq_o, 1'b1);
    @(posedge clk_sys_i);
    ovp <= 1'b0;
    $display("test otg done");
    // Grounded strap, then hand the regulator over to the host
    do_reset(1'b1);
    wb(1'b0, REG_CTRL_OFS, 32'h0);
    chk({phy_reg_on_o, phy_reg_from_boost_o, rd[2:0]}, 5'h1F);
    tick(40);
    wb(1'b0, REG_FLAG_OFS, 32'h0);
    chk(rd[1], 1'b1);
    wb(1'b1, REG_CTRL_OFS, 32'h03);
    wb(1'b1, REG_CTRL_OFS, 32'h02);
    wb(1'b1, REG_CTRL_OFS, 32'h06);
    tick(2);
    chk({phy_reg_on_o, phy_reg_from_boost_o, bus_switch_close_o}, 3'h4);
    $display("test handover done");
    complete_run();
  end
endmodule
